// ==== core/timer8_pkg.sv ====
package timer8_pkg;
    localparam logic [7:0]  ADR_CTRL   = 8'h00;
    localparam logic [7:0]  ADR_COUNT  = 8'h04;
    localparam logic [7:0]  ADR_CMPA   = 8'h08;
    localparam logic [7:0]  ADR_CMPB   = 8'h0C;
    localparam logic [7:0]  ADR_FLAGS  = 8'h10;
    localparam logic [7:0]  ADR_STATUS = 8'h14;

    localparam int          CTL_MODE_LSB = 0;
    localparam int          CTL_ACTA_LSB = 4;
    localparam int          CTL_ACTB_LSB = 6;
    localparam int          CTL_CLK_LSB  = 8;
    localparam int          CTL_DIRA_BIT = 12;
    localparam int          CTL_DIRB_BIT = 13;
    localparam int          CTL_PRTA_BIT = 14;
    localparam int          CTL_PRTB_BIT = 15;
    localparam int          FLG_OV       = 0;
    localparam int          FLG_CA       = 1;
    localparam int          FLG_CB       = 2;
    localparam int          ST_OCA       = 0;
    localparam int          ST_OCB       = 1;
    localparam int          ST_DOWN      = 2;

    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [7:0]  BOTTOM     = 8'h00;
    localparam logic [7:0]  MAX        = 8'hFF;
    localparam logic [2:0]  MODE_PC_FF = 3'h1;
    localparam logic [2:0]  MODE_CTC   = 3'h2;
    localparam logic [2:0]  MODE_FASTF = 3'h3;
    localparam logic [2:0]  MODE_PC_A  = 3'h5;
    localparam logic [2:0]  MODE_FASTA = 3'h7;
    localparam logic [1:0]  ACT_OFF    = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE = 2'h1;
    localparam logic [1:0]  ACT_NONINV = 2'h2;
    localparam logic [1:0]  ACT_INV    = 2'h3;

    typedef enum logic [1:0] {
        KIND_NORMAL,
        KIND_CTC,
        KIND_FAST,
        KIND_PC
    } kind_t;

    function automatic kind_t mode_kind(input logic [2:0] m);
        unique case (m)
            MODE_CTC:               return KIND_CTC;
            MODE_FASTF, MODE_FASTA: return KIND_FAST;
            MODE_PC_FF, MODE_PC_A:  return KIND_PC;
            default:                return KIND_NORMAL;
        endcase
    endfunction : mode_kind
endpackage : timer8_pkg

// ==== core/timer8_waveform_modes.sv ====
`timescale 1ns/1ps
// Functional notes
// R1: mode 2 clears the count to zero when it equals compare A.
// R2: mode 2 with compare A below count runs to 0xFF, wraps to 0x00.
// R3: mode 2 applies compare A writes at once, no buffering.
// R4: mode 2 with action 1 toggles output A on each compare A match.
// R5: a pin is driven only while its direction bit selects output.
// R6: mode 2 sets overflow flag as count passes from MAX to 0x00.
// R7: mode 2 sets compare flag A every time count reaches TOP.
// R8: fast PWM modes 3 and 7 count up; TOP is 0xFF or compare A.
// R9: fast PWM clears count to BOTTOM on the tick after matching TOP.
// R10: fast PWM action 2 clears on match, sets at BOTTOM; action 3 inverse.
// R11: fast PWM sets overflow flag each time count reaches TOP.
// R12: PWM action 1 toggles output A only with mode bit 2; never B.
// R13: timer clock divides the I/O clock by 1, 8, 64, 256 or 1024.
// R14: fast PWM compare BOTTOM gives spike, compare MAX a constant level.
// R15: fast PWM keeps compare buffering, toggle action included.
// R16: phase PWM modes 1 and 5 count up then down; TOP 0xFF or A.
// R17: phase PWM reverses direction at TOP without holding it; counts down on the next tick.
// R18: phase PWM non-inverting clears on up match, sets on down match.
// R19: phase PWM sets overflow flag each time count reaches BOTTOM.
// R20: phase PWM compare BOTTOM holds low, MAX holds high (non-inverting).
// R21: phase PWM forces the down-match level at BOTTOM for symmetry (up-match level when compare is BOTTOM).
// R22: compare flag is set on the tick after count equals compare.
// R23: a count write blocks compare matches until the next tick.
// R24: action 0 leaves the output register alone; pin follows port bit.
// R25: PWM compare buffers move to active registers only at TOP.
module timer8_waveform_modes
    import timer8_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             waveform_out_a,
    output logic             waveform_oe_a,
    output logic             waveform_out_b,
    output logic             waveform_oe_b
);
    logic [15:0] ctrl_q;
    logic [7:0]  cnt_q;
    logic [7:0]  cnt_d;
    logic        up_q;
    logic        up_d;
    logic [7:0]  buf_a_q;
    logic [7:0]  buf_b_q;
    logic [7:0]  cmp_a_q;
    logic [7:0]  cmp_b_q;
    logic        blk_q;
    logic [2:0]  flags_q;
    logic [2:0]  flag_set;
    logic [2:0]  flag_clr;
    logic        oc_a_q;
    logic        oc_b_q;
    logic [9:0]  pre_q;
    logic        tick;
    logic        ack_q;
    logic [31:0] dat_q;
    logic [31:0] rdata;
    logic        req;
    logic        wr;
    kind_t       kind;
    logic [2:0]  mode;
    logic [1:0]  act_a;
    logic [1:0]  act_b;
    logic [2:0]  clk_sel;
    logic [7:0]  top;
    logic        at_top;
    logic        match_a;
    logic        match_b;
    logic        wrap;
    logic        bot_turn;
    logic        ov_set;
    logic        load;
    logic        cnt_wr;
    logic        pwm;

    assign mode    = ctrl_q[CTL_MODE_LSB +: 3];
    assign act_a   = ctrl_q[CTL_ACTA_LSB +: 2];
    assign act_b   = ctrl_q[CTL_ACTB_LSB +: 2];
    assign clk_sel = ctrl_q[CTL_CLK_LSB +: 3];
    assign kind    = mode_kind(mode);
    assign pwm     = kind == KIND_FAST || kind == KIND_PC;

    // bus side: ack one cycle after request, write lands on the ack edge
    assign req    = wb_cyc_i & wb_stb_i;
    assign wr     = req & wb_we_i & ack_q;
    assign cnt_wr = wr & (wb_adr_i == ADR_COUNT) & wb_sel_i[0];

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            ADR_CTRL:   rdata[15:0] = ctrl_q;
            ADR_COUNT:  rdata[7:0]  = cnt_q;
            ADR_CMPA:   rdata[7:0]  = buf_a_q;
            ADR_CMPB:   rdata[7:0]  = buf_b_q;
            ADR_FLAGS:  rdata[2:0]  = flags_q;
            ADR_STATUS: rdata[2:0]  = {~up_q, oc_b_q, oc_a_q};
            default:    rdata       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (ce) begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                dat_q <= rdata;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_q <= CTRL_RST;
        end else if (ce && wr && wb_adr_i == ADR_CTRL) begin
            if (wb_sel_i[0]) begin
                ctrl_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                ctrl_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // prescaler: select 0 stops the timer, 1..5 pick the divider
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pre_q <= 10'h000;
        end else if (ce) begin
            pre_q <= pre_q + 10'h001;
        end
    end

    always_comb begin
        unique case (clk_sel)
            3'h1:    tick = 1'b1;                 // [R13]
            3'h2:    tick = &pre_q[2:0];          // [R13]
            3'h3:    tick = &pre_q[5:0];          // [R13]
            3'h4:    tick = &pre_q[7:0];          // [R13]
            3'h5:    tick = &pre_q;               // [R13]
            default: tick = 1'b0;
        endcase
    end

    // mode 2 takes compare A as TOP although bit 2 is clear
    assign top      = (kind == KIND_CTC || mode[2]) ? cmp_a_q : MAX; // [R8] [R16]
    assign at_top   = cnt_q == top;
    assign match_a  = cnt_q == cmp_a_q && !blk_q; // [R23]
    assign match_b  = cnt_q == cmp_b_q && !blk_q; // [R23]
    assign wrap     = kind == KIND_FAST && at_top;
    assign bot_turn = kind == KIND_PC && !up_q && cnt_q == BOTTOM;

    always_comb begin
        up_d  = 1'b1;
        cnt_d = cnt_q + 8'h01;
        unique case (kind)
            KIND_CTC: begin
                if (match_a) begin
                    cnt_d = BOTTOM;               // [R1]
                end
            end
            KIND_FAST: begin
                if (at_top) begin
                    cnt_d = BOTTOM;               // [R8] [R9]
                end
            end
            KIND_PC: begin
                if (up_q) begin
                    up_d = !at_top;               // [R17]
                    if (at_top) begin
                        // top of zero would underflow, so stay put
                        cnt_d = (cnt_q == BOTTOM) ? cnt_q : cnt_q - 8'h01; // [R16] [R17]
                    end
                end else begin
                    up_d = cnt_q == BOTTOM;       // [R16]
                    if (cnt_q != BOTTOM) begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
            end
            KIND_NORMAL: cnt_d = cnt_q + 8'h01;
        endcase
    end

    // plain wrap past 0xFF gives the missed-match behaviour for free
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_q <= BOTTOM;
            up_q  <= 1'b1;
            blk_q <= 1'b0;
        end else if (ce) begin
            if (cnt_wr) begin
                cnt_q <= wb_dat_i[7:0];
                blk_q <= 1'b1;                    // [R23]
            end else if (tick) begin
                cnt_q <= cnt_d;                   // [R2]
                up_q  <= up_d;
                blk_q <= 1'b0;                    // [R23]
            end
        end
    end

    always_comb begin
        unique case (kind)
            KIND_FAST: ov_set = at_top;           // [R11]
            KIND_PC:   ov_set = bot_turn;         // [R19]
            default:   ov_set = cnt_q == MAX && cnt_d == BOTTOM; // [R6]
        endcase
    end

    assign flag_set = tick ? {match_b, match_a, ov_set} : 3'h0; // [R7] [R22]
    assign flag_clr = (wr && wb_adr_i == ADR_FLAGS && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;

    // a set in the same cycle as a clear wins
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            flags_q <= 3'h0;
        end else if (ce) begin
            flags_q <= (flags_q & ~flag_clr) | flag_set; // [R22]
        end
    end

    // compare buffers: direct outside PWM, moved only at TOP in PWM
    assign load = pwm ? (tick && at_top && (up_q || kind == KIND_FAST)) : 1'b1; // [R3] [R15] [R25]

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            buf_a_q <= BOTTOM;
            buf_b_q <= BOTTOM;
            cmp_a_q <= BOTTOM;
            cmp_b_q <= BOTTOM;
        end else if (ce) begin
            if (wr && wb_sel_i[0] && wb_adr_i == ADR_CMPA) begin
                buf_a_q <= wb_dat_i[7:0];
            end
            if (wr && wb_sel_i[0] && wb_adr_i == ADR_CMPB) begin
                buf_b_q <= wb_dat_i[7:0];
            end
            if (load) begin
                cmp_a_q <= buf_a_q;               // [R25]
                cmp_b_q <= buf_b_q;               // [R25]
            end
        end
    end

    function automatic logic next_oc(
        input kind_t      k,
        input logic [1:0] act,
        input logic       oc,
        input logic       tgl_ok,
        input logic       m,
        input logic       wr_top,
        input logic       t_top,
        input logic       up,
        input logic       b_turn,
        input logic       c_zero
    );
        logic r;
        r = oc;
        unique case (k)
            KIND_NORMAL, KIND_CTC: begin
                if (m && act == ACT_TOGGLE) begin
                    r = ~oc;                      // [R4]
                end else if (m && act[1]) begin
                    r = act[0];
                end
            end
            KIND_FAST: begin
                if (wr_top && act[1]) begin
                    r = ~act[0];                  // [R10] [R14]
                end else if (m && act[1]) begin
                    r = act[0];                   // [R10]
                end else if (m && act == ACT_TOGGLE && tgl_ok) begin
                    r = ~oc;                      // [R12] [R15]
                end
            end
            KIND_PC: begin
                if (b_turn && act[1]) begin
                    r = ~(act[0] ^ c_zero);       // [R20] [R21]
                end else if (m && act[1]) begin
                    r = (up && !t_top) ? act[0] : ~act[0]; // [R18] [R20]
                end else if (m && act == ACT_TOGGLE && tgl_ok) begin
                    r = ~oc;                      // [R12]
                end
            end
        endcase
        return r;                                 // [R24]
    endfunction : next_oc

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            oc_a_q <= 1'b0;
            oc_b_q <= 1'b0;
        end else if (ce && tick) begin
            oc_a_q <= next_oc(kind, act_a, oc_a_q, mode[2], match_a, wrap,
                              at_top, up_q, bot_turn, cmp_a_q == BOTTOM);
            oc_b_q <= next_oc(kind, act_b, oc_b_q, 1'b0, match_b, wrap,
                              at_top, up_q, bot_turn, cmp_b_q == BOTTOM); // [R12]
        end
    end

    // pin stage: action 0, or a toggle pwm cannot serve, hands the pin to the port bit
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            waveform_out_a <= 1'b0;
            waveform_oe_a  <= 1'b0;
            waveform_out_b <= 1'b0;
            waveform_oe_b  <= 1'b0;
        end else if (ce) begin
            waveform_oe_a  <= ctrl_q[CTL_DIRA_BIT]; // [R5]
            waveform_oe_b  <= ctrl_q[CTL_DIRB_BIT]; // [R5]
            waveform_out_a <= (act_a[1] || (act_a[0] && (mode[2] || !pwm))) ? oc_a_q : ctrl_q[CTL_PRTA_BIT]; // [R12]
            waveform_out_b <= (act_b[1] || (act_b[0] && !pwm)) ? oc_b_q : ctrl_q[CTL_PRTB_BIT]; // [R12] [R24]
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    property p_ctc_clear;
        ce && tick && kind == KIND_CTC && match_a && !cnt_wr |=> cnt_q == BOTTOM;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("ctc count not cleared"); // [R1]

    property p_ctc_wrap;
        ce && tick && kind == KIND_CTC && cnt_q == MAX && !cnt_wr |=> cnt_q == BOTTOM;
    endproperty
    a_ctc_wrap: assert property (p_ctc_wrap) else $error("ctc count did not wrap"); // [R2]

    property p_ctc_direct;
        ce && kind == KIND_CTC |=> !ce || cmp_a_q == $past(buf_a_q);
    endproperty
    a_ctc_direct: assert property (p_ctc_direct) else $error("ctc compare buffered"); // [R3]

    property p_ctc_toggle;
        ce && tick && kind == KIND_CTC && match_a && act_a == ACT_TOGGLE |=> oc_a_q != $past(oc_a_q);
    endproperty
    a_ctc_toggle: assert property (p_ctc_toggle) else $error("ctc toggle missed"); // [R4]

    property p_pin_dir;
        ce |=> waveform_oe_a == $past(ctrl_q[CTL_DIRA_BIT]);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin enable wrong"); // [R5]

    property p_ov;
        ce && tick && ov_set |=> flags_q[FLG_OV];
    endproperty
    a_ov: assert property (p_ov) else $error("overflow flag not set"); // [R6]

    property p_fast_restart;
        ce && tick && kind == KIND_FAST && at_top && !cnt_wr |=> cnt_q == BOTTOM;
    endproperty
    a_fast_restart: assert property (p_fast_restart) else $error("fast restart wrong"); // [R9]

    property p_fast_bottom;
        ce && tick && wrap && act_a == ACT_NONINV ##1 ce |-> oc_a_q;
    endproperty
    a_fast_bottom: assert property (p_fast_bottom) else $error("fast set at bottom missed"); // [R10]

    property p_pc_top;
        ce && tick && kind == KIND_PC && up_q && at_top && cnt_q != BOTTOM && !cnt_wr
            |=> !up_q && cnt_q == $past(cnt_q) - 8'h01;
    endproperty
    a_pc_top: assert property (p_pc_top) else $error("phase top turn wrong"); // [R17]

    property p_flag_a;
        ce && tick && match_a |=> flags_q[FLG_CA];
    endproperty
    a_flag_a: assert property (p_flag_a) else $error("compare flag a not set"); // [R22]

    property p_block;
        ce && tick && blk_q && !flags_q[FLG_CA] |=> !flags_q[FLG_CA];
    endproperty
    a_block: assert property (p_block) else $error("blocked match set flag"); // [R23]

    property p_pwm_hold;
        ce && (kind == KIND_FAST || kind == KIND_PC) && !load && $stable(mode) |=> $stable(cmp_a_q);
    endproperty
    a_pwm_hold: assert property (p_pwm_hold) else $error("compare moved mid period"); // [R25]

    c_ctc_match: cover property (ce && tick && kind == KIND_CTC && match_a);
    c_fast_wrap: cover property (ce && tick && wrap && act_a == ACT_NONINV);
    c_pc_turn:   cover property (ce && tick && bot_turn && act_b == ACT_INV);
endmodule : timer8_waveform_modes

// ==== test/tb_timer8_waveform_modes.sv ====
`timescale 1ns/1ps
module tb_timer8_waveform_modes;
    import timer8_pkg::*;
    logic        mclk   = 1'b0;
    logic        resetn = 1'b0;
    logic        ce     = 1'b1;
    logic        cyc    = 1'b0;
    logic        stb    = 1'b0;
    logic        we     = 1'b0;
    logic [7:0]  adr    = 8'h00;
    logic [3:0]  sel    = 4'h0;
    logic [31:0] wdat   = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic        oa;
    logic        oea;
    logic        ob;
    logic        oeb;
    logic [31:0] rd;
    logic [1:0]  prv    = 2'b00;
    logic [1:0]  pins;
    logic        half   = 1'b0;
    logic        inv;
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          seed       = 48;
    int          c;
    int          per[2];
    int          hi[2];
    int          run[2];
    int          rises[2];
    int          dv[6] = '{0, 1, 8, 64, 256, 1024};

    always #2.5 mclk = ~mclk;

    // half-rate enable must stretch every waveform by exactly two
    always @(posedge mclk) ce <= half ? ~ce : 1'b1;

    assign pins = {ob, oa};

    timer8_waveform_modes timer8_waveform_modes_i (
        .mclk           (mclk),
        .resetn         (resetn),
        .ce             (ce),
        .wb_cyc_i       (cyc),
        .wb_stb_i       (stb),
        .wb_we_i        (we),
        .wb_adr_i       (adr),
        .wb_sel_i       (sel),
        .wb_dat_i       (wdat),
        .wb_dat_o       (rdat),
        .wb_ack_o       (ack),
        .waveform_out_a (oa),
        .waveform_oe_a  (oea),
        .waveform_out_b (ob),
        .waveform_oe_b  (oeb)
    );

    // edge-to-edge meter on both pins: high time and period in mclk cycles
    always @(posedge mclk) begin
        for (int k = 0; k < 2; k++) begin
            if (pins[k] && !prv[k]) begin
                per[k] <= run[k];
                run[k] <= 1;
                rises[k] <= rises[k] + 1;
            end else begin
                run[k] <= run[k] + 1;
            end
            if (!pins[k] && prv[k]) begin
                hi[k] <= run[k];
            end
        end
        prv <= pins;
    end

    task conclude;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; request held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) num_errors++;
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdchk

    task waitr(input int k, input int n);
        int r0;
        int t;
        r0 = rises[k];
        t = 0;
        while (rises[k] < r0 + n && t < 20000) begin
            @(posedge mclk);
            t++;
        end
        if (t == 20000) num_errors++;
    endtask : waitr

    task wavechk(input int k, input int p, input int h);
        waitr(k, 3);
        chk(per[k], p);
        chk(hi[k], h);
    endtask : wavechk

    // no pin may move; rise count must stay put
    task steady(input logic la, input logic lb);
        int r0;
        repeat (600) @(posedge mclk);
        r0 = rises[0] + rises[1];
        repeat (1100) @(posedge mclk);
        chk({oa, ob}, {la, lb});
        chk(rises[0] + rises[1], r0);
    endtask : steady

    function automatic logic [31:0] cw(input logic [2:0] m, input logic [1:0] a,
                                       input logic [1:0] b, input logic [2:0] k);
        return (32'(m) << CTL_MODE_LSB) | (32'(a) << CTL_ACTA_LSB) | (32'(b) << CTL_ACTB_LSB)
             | (32'(k) << CTL_CLK_LSB) | (32'h3 << CTL_DIRA_BIT);
    endfunction : cw

    // compare buffers written first, ctrl after the old mode passed its top
    task cfg(input logic [31:0] w, input logic [7:0] a, input logic [7:0] b);
        wb(1'b1, ADR_CMPA, {24'h00_0000, a});
        wb(1'b1, ADR_CMPB, {24'h00_0000, b});
        repeat (520) @(posedge mclk);
        wb(1'b1, ADR_CTRL, w);
    endtask : cfg

    initial begin
        fork
            begin
                #450_000;
                num_errors++;
                conclude();
            end
        join_none
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        wb(1'b1, 8'h18, 32'hFFFF_FFFF);
        for (int a = 0; a <= 24; a += 4) rdchk(8'(a), 32'h0000_0000);
        wb(1'b1, ADR_CTRL, (32'h1 << CTL_DIRA_BIT) | (32'h3 << CTL_PRTA_BIT));
        repeat (3) @(posedge mclk);
        chk({oea, oeb, oa}, 3'b101);
        wb(1'b1, ADR_CTRL, 32'h1 << CTL_DIRB_BIT);
        repeat (3) @(posedge mclk);
        chk({oea, oeb, oa, ob}, 4'b0100);
        for (int k = 1; k <= 5; k++) begin
            cfg(cw(MODE_CTC, ACT_TOGGLE, ACT_OFF, 3'(k)), 8'h01, 8'h00);
            wavechk(0, 4 * dv[k], 2 * dv[k]);
        end
        cfg(cw(MODE_CTC, ACT_TOGGLE, ACT_OFF, 3'h1), 8'hC8, 8'h00);
        waitr(0, 2);
        wb(1'b1, ADR_CMPA, 32'h0000_000A);
        waitr(0, 1);
        chk(hi[0], 11);
        // stopped timer: count written equal to compare b, top below count
        wb(1'b1, ADR_CTRL, cw(MODE_CTC, ACT_OFF, ACT_OFF, 3'h0));
        wb(1'b1, ADR_CMPA, 32'h0000_0032);
        wb(1'b1, ADR_CMPB, 32'h0000_00C8);
        wb(1'b1, ADR_COUNT, 32'h0000_00C8);
        wb(1'b1, ADR_FLAGS, 32'h0000_0007);
        wb(1'b1, ADR_CTRL, cw(MODE_CTC, ACT_OFF, ACT_OFF, 3'h1));
        repeat (30) @(posedge mclk);
        rdchk(ADR_FLAGS, 32'h0000_0000);
        repeat (30) @(posedge mclk);
        rdchk(ADR_FLAGS, 32'h0000_0001);
        repeat (60) @(posedge mclk);
        rdchk(ADR_FLAGS, 32'h0000_0003);
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 0 : 1 + ($unsigned($random(seed)) % 254);
            inv = 1'($random(seed) & 1);
            cfg(cw(MODE_FASTF, inv ? ACT_INV : ACT_NONINV, ACT_OFF, 3'h1), 8'(c), 8'h00);
            wavechk(0, 256, inv ? 255 - c : c + 1);
        end
        // enable low every other cycle: no bus traffic while it toggles
        half <= 1'b1;
        wavechk(0, 512, 2 * (inv ? 255 - c : c + 1));
        half <= 1'b0;
        cfg(cw(MODE_FASTA, ACT_TOGGLE, ACT_NONINV, 3'h1), 8'h63, 8'h14);
        wavechk(0, 200, 100);
        wavechk(1, 100, 21);
        cfg(cw(MODE_FASTF, ACT_TOGGLE, ACT_TOGGLE, 3'h1) | (32'h1 << CTL_PRTA_BIT), 8'h40, 8'h40);
        steady(1'b1, 1'b0);
        cfg(cw(MODE_FASTF, ACT_NONINV, ACT_INV, 3'h1), 8'hFF, 8'hFF);
        steady(1'b1, 1'b0);
        cfg(cw(MODE_PC_FF, ACT_NONINV, ACT_NONINV, 3'h1), 8'h00, 8'hFF);
        steady(1'b0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            c = 1 + ($unsigned($random(seed)) % 254);
            inv = 1'($random(seed) & 1);
            cfg(cw(MODE_PC_FF, inv ? ACT_INV : ACT_NONINV, ACT_OFF, 3'h1), 8'(c), 8'h00);
            wavechk(0, 510, inv ? 510 - 2 * c : 2 * c);
        end
        cfg(cw(MODE_PC_A, ACT_TOGGLE, ACT_NONINV, 3'h1), 8'h64, 8'h1E);
        wavechk(0, 400, 200);
        wavechk(1, 200, 60);
        // mid-period compare write must wait for the top
        cfg(cw(MODE_FASTF, ACT_NONINV, ACT_OFF, 3'h1), 8'h32, 8'h00);
        waitr(0, 3);
        wb(1'b1, ADR_CMPA, 32'h0000_00C8);
        waitr(0, 1);
        chk(hi[0], 51);
        waitr(0, 1);
        chk(hi[0], 201);
        wb(1'b1, ADR_FLAGS, 32'h0000_0007);
        wb(1'b0, ADR_FLAGS, 32'h0000_0000);
        chk(rd[1:0], 2'b00);
        repeat (230) @(posedge mclk);
        wb(1'b0, ADR_FLAGS, 32'h0000_0000);
        chk(rd[1:0], 2'b10);
        repeat (30) @(posedge mclk);
        wb(1'b0, ADR_FLAGS, 32'h0000_0000);
        chk(rd[1:0], 2'b11);
        cfg(cw(MODE_PC_FF, ACT_NONINV, ACT_OFF, 3'h1), 8'h64, 8'h00);
        waitr(0, 2);
        wb(1'b1, ADR_FLAGS, 32'h0000_0007);
        repeat (120) @(posedge mclk);
        wb(1'b0, ADR_FLAGS, 32'h0000_0000);
        chk(rd[1:0], 2'b01);
        conclude();
    end
endmodule : tb_timer8_waveform_modes
